// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  ssim_pkg::ssim_bus_req_t bus_req = '0;
  ssim_pkg::ssim_src_t src = '0;
  logic [31:0] rdata;
  logic irq;
  logic [11:0] model_mask = 12'h000;
  int mismatches = 0;
  int total_checks = 0;

  always #50 clk_sys = ~clk_sys;

  ssim_irq_mask uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata), .src(src), .irq(irq));

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t read data %h expected %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_irq(input logic exp);
    repeat (3) @(posedge clk_sys);
    #1;
    total_checks++;
    if (irq !== exp)
    begin
      mismatches++;
      $display("Error %0t interrupt %b expected %b", $time, irq, exp);
    end
  endtask : cmp_irq

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
    if (a == ssim_pkg::OFS_ENABLE_SET)
      model_mask = model_mask | d[11:0];
    if (a == ssim_pkg::OFS_ENABLE_CLEAR)
      model_mask = model_mask & ~d[11:0];
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 d = rdata;
  endtask : bus_rd

  // one source active, sticky ones as a single event pulse
  function automatic ssim_pkg::ssim_src_t src_for(input int i);
    ssim_pkg::ssim_src_t s;
    s = '0;
    case (i)
      0: s.tx_holding_free = 1'b1;
      1: s.tx_all_drained = 1'b1;
      2: s.tx_dma_count_end = 1'b1;
      3: {s.tx_dma_counter_zero, s.tx_dma_next_counter_zero} = 2'b11;
      4: s.rx_word_available = 1'b1;
      5: s.rx_overrun_event = 1'b1;
      6: s.rx_dma_count_end = 1'b1;
      7: {s.rx_dma_counter_zero, s.rx_dma_next_counter_zero} = 2'b11;
      8: s.compare_zero_event = 1'b1;
      9: s.compare_one_event = 1'b1;
      10: s.tx_sync_event = 1'b1;
      default: s.rx_sync_event = 1'b1;
    endcase
    return s;
  endfunction : src_for

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("Error %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    logic [31:0] d;
    logic [31:0] bit_val;
    int unsigned r;
    logic sticky;
    r = $urandom(32'h208c);
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus_rd(ssim_pkg::OFS_MASK_VIEW, d);
    cmp_data(d, 32'h0000_0000);
    cmp_irq(1'b0);
    for (int n = 0; n < 80; n++)
    begin
      r = $urandom;
      if (r % 3 == 0)
        bus_wr(ssim_pkg::OFS_ENABLE_SET, $urandom);
      else if (r % 3 == 1)
        bus_wr(ssim_pkg::OFS_ENABLE_CLEAR, $urandom);
      else
      begin
        bus_rd(ssim_pkg::OFS_MASK_VIEW, d);
        cmp_data(d, {20'h00000, model_mask});
      end
    end
    bus_wr(ssim_pkg::OFS_MASK_VIEW, 32'h0000_0fff);
    bus_rd(8'h10, d);
    cmp_data(d, 32'h0000_0000);
    bus_rd(ssim_pkg::OFS_MASK_VIEW, d);
    cmp_data(d, {20'h00000, model_mask});
    for (int i = 0; i < 12; i++)
    begin
      bit_val = 32'h0000_0001 << i;
      sticky = ssim_pkg::STICKY_BITS[i];
      bus_wr(ssim_pkg::OFS_ENABLE_CLEAR, 32'hffff_ffff);
      @(posedge clk_sys);
      src <= src_for(i);
      @(posedge clk_sys);
      if (sticky)
        src <= '0;
      cmp_irq(1'b0);
      bus_wr(ssim_pkg::OFS_ENABLE_SET, bit_val);
      cmp_irq(1'b1);
      bus_rd(ssim_pkg::OFS_STATUS, d);
      cmp_data(d, bit_val);
      bus_rd(ssim_pkg::OFS_STATUS, d);
      cmp_data(d, sticky ? 32'h0000_0000 : bit_val);
      bus_wr(ssim_pkg::OFS_ENABLE_CLEAR, bit_val);
      cmp_irq(1'b0);
      @(posedge clk_sys);
      src <= '0;
    end
    @(posedge clk_sys);
    src.tx_dma_counter_zero <= 1'b1;
    src.rx_dma_next_counter_zero <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus_rd(ssim_pkg::OFS_STATUS, d);
    cmp_data(d, 32'h0000_0000);
    conclude();
  end
endmodule : testbench

// file: src/ssim_irq_mask.sv
`timescale 1ns/1ps
// How it works
// - a one written to the enable register sets that mask bit, zeros leave it alone.
// - a one written to the disable register clears that mask bit, zeros change nothing.
// - reading the mask register shows one for every enabled source and zero otherwise.
// - transmit sources sit at bits 0 to 3: holding free, drained, count end, buffers empty.
// - receive sources sit at bits 4 to 7: word available, overrun, count end, buffers full.
// - compare and sync sources sit at bits 8 to 11: compare zero, compare one, tx sync, rx sync.
// - a one at bit 10 or 11 of the disable register clears those mask bits like any other.
// - compare, sync and overrun flags are sticky and cleared by a status register read.
// - the holding free flag is one while the transmit holding register is empty.
// - buffers empty and buffers full read one only when both dma counters are zero.
module ssim_irq_mask
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ssim_pkg::ssim_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire ssim_pkg::ssim_src_t src,
  output logic irq
);
  logic [ssim_pkg::SRC_W-1:0] irq_mask;
  logic [ssim_pkg::SRC_W-1:0] status;
  logic [ssim_pkg::SRC_W-1:0] sticky_set;
  logic [ssim_pkg::SRC_W-1:0] sticky_q;
  logic [ssim_pkg::SRC_W-1:0] next_rdata_low;
  logic wr_set;
  logic wr_clr;
  logic rd_status;
  logic rd_mask;

  assign wr_set = bus_req.wr && (bus_req.addr == ssim_pkg::OFS_ENABLE_SET);
  assign wr_clr = bus_req.wr && (bus_req.addr == ssim_pkg::OFS_ENABLE_CLEAR);
  assign rd_status = bus_req.rd && (bus_req.addr == ssim_pkg::OFS_STATUS);
  assign rd_mask = bus_req.rd && (bus_req.addr == ssim_pkg::OFS_MASK_VIEW);

  // mask update, set and clear registers are separate addresses
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      irq_mask <= ssim_pkg::MASK_RESET;
    else if (wr_set)
      irq_mask <= irq_mask | bus_req.wdata[ssim_pkg::SRC_W-1:0];
    else if (wr_clr)
      irq_mask <= irq_mask & ~bus_req.wdata[ssim_pkg::SRC_W-1:0];
  end

  // sticky event bits
  always_comb
  begin
    sticky_set = '0;
    sticky_set[ssim_pkg::BIT_RX_OVERRUN_FLAG] = src.rx_overrun_event;
    sticky_set[ssim_pkg::BIT_COMPARE_ZERO_HIT] = src.compare_zero_event;
    sticky_set[ssim_pkg::BIT_COMPARE_ONE_HIT] = src.compare_one_event;
    sticky_set[ssim_pkg::BIT_TX_SYNC_EVENT] = src.tx_sync_event;
    sticky_set[ssim_pkg::BIT_RX_SYNC_EVENT] = src.rx_sync_event;
  end

  genvar gi;
  generate
    for (gi = 0; gi < ssim_pkg::SRC_W; gi++)
    begin : g_sticky
      if (ssim_pkg::STICKY_BITS[gi])
      begin : g_on
        ssim_sticky u_sticky
        (
          .clk_sys(clk_sys),
          .sys_rst(sys_rst),
          .set_evt(sticky_set[gi]),
          .clr_evt(rd_status),
          .flag(sticky_q[gi])
        );
      end
      else
      begin : g_off
        assign sticky_q[gi] = 1'b0;
      end
    end
  endgenerate

  // status vector in documented bit order
  always_comb
  begin
    status = ssim_pkg::STATUS_RESET;
    status[ssim_pkg::BIT_TX_HOLDING_FREE] = src.tx_holding_free;
    status[ssim_pkg::BIT_TX_ALL_DRAINED] = src.tx_all_drained;
    status[ssim_pkg::BIT_TX_DMA_COUNT_END] = src.tx_dma_count_end;
    status[ssim_pkg::BIT_TX_DMA_BUFFERS_EMPTY] =
      src.tx_dma_counter_zero && src.tx_dma_next_counter_zero;
    status[ssim_pkg::BIT_RX_WORD_AVAILABLE] = src.rx_word_available;
    status[ssim_pkg::BIT_RX_OVERRUN_FLAG] = sticky_q[ssim_pkg::BIT_RX_OVERRUN_FLAG];
    status[ssim_pkg::BIT_RX_DMA_COUNT_END] = src.rx_dma_count_end;
    status[ssim_pkg::BIT_RX_DMA_BUFFERS_FULL] =
      src.rx_dma_counter_zero && src.rx_dma_next_counter_zero;
    status[ssim_pkg::BIT_COMPARE_ZERO_HIT] = sticky_q[ssim_pkg::BIT_COMPARE_ZERO_HIT];
    status[ssim_pkg::BIT_COMPARE_ONE_HIT] = sticky_q[ssim_pkg::BIT_COMPARE_ONE_HIT];
    status[ssim_pkg::BIT_TX_SYNC_EVENT] = sticky_q[ssim_pkg::BIT_TX_SYNC_EVENT];
    status[ssim_pkg::BIT_RX_SYNC_EVENT] = sticky_q[ssim_pkg::BIT_RX_SYNC_EVENT];
  end

  // interrupt line
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(status & irq_mask);
  end

  // read data, one cycle after the strobe
  always_comb
  begin
    next_rdata_low = '0;
    if (rd_mask)
      next_rdata_low = irq_mask;
    else if (rd_status)
      next_rdata_low = status;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= ssim_pkg::UNMAPPED_READ;
    else if (bus_req.rd)
      rdata <= {20'h00000, next_rdata_low};
    else
      rdata <= ssim_pkg::UNMAPPED_READ;
  end

  a_enable_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_set |=> ((irq_mask & $past(bus_req.wdata[ssim_pkg::SRC_W-1:0]))
      == $past(bus_req.wdata[ssim_pkg::SRC_W-1:0])))
    else $error("enable write did not set mask bits");

  a_enable_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_set |=> ((irq_mask & $past(irq_mask)) == $past(irq_mask)))
    else $error("enable write cleared a mask bit");

  a_disable_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_clr |=> ((irq_mask & $past(bus_req.wdata[ssim_pkg::SRC_W-1:0])) == '0))
    else $error("disable write left a mask bit set");

  a_disable_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_clr |=> ((irq_mask | $past(bus_req.wdata[ssim_pkg::SRC_W-1:0]))
      == ($past(irq_mask) | $past(bus_req.wdata[ssim_pkg::SRC_W-1:0]))))
    else $error("disable write set a mask bit");

  a_sync_disable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_clr && bus_req.wdata[ssim_pkg::BIT_RX_SYNC_EVENT]) |=> !irq_mask[ssim_pkg::BIT_RX_SYNC_EVENT])
    else $error("rx sync disable failed");

  a_mask_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_mask && !wr_set && !wr_clr) |=> (rdata == {20'h00000, $past(irq_mask)}))
    else $error("mask read data wrong");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (irq == |($past(status) & $past(irq_mask))))
    else $error("interrupt level wrong");

  a_sticky_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && !src.compare_zero_event) |=> !status[ssim_pkg::BIT_COMPARE_ZERO_HIT])
    else $error("compare flag not cleared by status read");

  a_buf_empty: assert property (@(posedge clk_sys) disable iff (sys_rst)
    status[ssim_pkg::BIT_TX_DMA_BUFFERS_EMPTY] |-> (src.tx_dma_counter_zero && src.tx_dma_next_counter_zero))
    else $error("buffers empty without both counters zero");

  a_holding_free: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_TX_HOLDING_FREE] == $past(src.tx_holding_free)))
    else $error("holding free read wrong");

  // register bus and read path
  a_enable_exact: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_set |=> (irq_mask == ($past(irq_mask) | $past(bus_req.wdata[ssim_pkg::SRC_W-1:0]))))
    else $error("enable write changed the wrong mask bits");

  a_disable_exact: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_clr |=> (irq_mask == ($past(irq_mask) & ~$past(bus_req.wdata[ssim_pkg::SRC_W-1:0]))))
    else $error("disable write changed the wrong mask bits");

  a_mask_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!wr_set && !wr_clr) |=> $stable(irq_mask))
    else $error("mask changed without a write");

  a_tx_sync_disable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_clr && bus_req.wdata[ssim_pkg::BIT_TX_SYNC_EVENT]) |=> !irq_mask[ssim_pkg::BIT_TX_SYNC_EVENT])
    else $error("tx sync disable failed");

  a_tx_sync_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_set && bus_req.wdata[ssim_pkg::BIT_TX_SYNC_EVENT]) |=> irq_mask[ssim_pkg::BIT_TX_SYNC_EVENT])
    else $error("tx sync enable failed");

  a_rx_sync_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_set && bus_req.wdata[ssim_pkg::BIT_RX_SYNC_EVENT]) |=> irq_mask[ssim_pkg::BIT_RX_SYNC_EVENT])
    else $error("rx sync enable failed");

  a_status_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata == {20'h00000, $past(status)}))
    else $error("status read data wrong");

  a_upper_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rdata[31:ssim_pkg::SRC_W] == '0)
    else $error("upper read bits not zero");

  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !bus_req.rd |=> (rdata == ssim_pkg::UNMAPPED_READ))
    else $error("read data not zero outside a read");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (bus_req.rd && !rd_status && !rd_mask) |=> (rdata == ssim_pkg::UNMAPPED_READ))
    else $error("unmapped read not zero");

  // status bit positions
  a_rd_tx_drained: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_TX_ALL_DRAINED] == $past(src.tx_all_drained)))
    else $error("drained bit read wrong");

  a_rd_tx_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_TX_DMA_COUNT_END] == $past(src.tx_dma_count_end)))
    else $error("tx count end bit read wrong");

  a_rd_tx_bufe: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_TX_DMA_BUFFERS_EMPTY]
      == $past(src.tx_dma_counter_zero && src.tx_dma_next_counter_zero)))
    else $error("buffers empty bit read wrong");

  a_rd_rx_avail: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_RX_WORD_AVAILABLE] == $past(src.rx_word_available)))
    else $error("word available bit read wrong");

  a_rd_rx_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_RX_DMA_COUNT_END] == $past(src.rx_dma_count_end)))
    else $error("rx count end bit read wrong");

  a_rd_rx_buff: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_status |=> (rdata[ssim_pkg::BIT_RX_DMA_BUFFERS_FULL]
      == $past(src.rx_dma_counter_zero && src.rx_dma_next_counter_zero)))
    else $error("buffers full bit read wrong");

  a_rx_buf_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
    status[ssim_pkg::BIT_RX_DMA_BUFFERS_FULL] |-> (src.rx_dma_counter_zero && src.rx_dma_next_counter_zero))
    else $error("buffers full without both counters zero");

  // sticky flags
  a_ovr_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src.rx_overrun_event |=> status[ssim_pkg::BIT_RX_OVERRUN_FLAG])
    else $error("overrun event not latched");

  a_cmp0_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src.compare_zero_event |=> status[ssim_pkg::BIT_COMPARE_ZERO_HIT])
    else $error("compare zero event not latched");

  a_cmp1_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src.compare_one_event |=> status[ssim_pkg::BIT_COMPARE_ONE_HIT])
    else $error("compare one event not latched");

  a_tx_sync_event_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src.tx_sync_event |=> status[ssim_pkg::BIT_TX_SYNC_EVENT])
    else $error("tx sync event not latched");

  a_rx_sync_event_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src.rx_sync_event |=> status[ssim_pkg::BIT_RX_SYNC_EVENT])
    else $error("rx sync event not latched");

  a_ovr_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && !src.rx_overrun_event) |=> !status[ssim_pkg::BIT_RX_OVERRUN_FLAG])
    else $error("overrun flag not cleared by status read");

  a_cmp1_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && !src.compare_one_event) |=> !status[ssim_pkg::BIT_COMPARE_ONE_HIT])
    else $error("compare one flag not cleared by status read");

  a_tx_sync_event_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && !src.tx_sync_event) |=> !status[ssim_pkg::BIT_TX_SYNC_EVENT])
    else $error("tx sync flag not cleared by status read");

  a_rx_sync_event_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && !src.rx_sync_event) |=> !status[ssim_pkg::BIT_RX_SYNC_EVENT])
    else $error("rx sync flag not cleared by status read");

  a_sticky_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rd_status |=> ((sticky_q & $past(sticky_q)) == $past(sticky_q)))
    else $error("sticky flag dropped without a status read");

  a_rd_ovr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && $past(src.rx_overrun_event)) |=> rdata[ssim_pkg::BIT_RX_OVERRUN_FLAG])
    else $error("overrun flag missing from status read");

  a_rd_cmp0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && $past(src.compare_zero_event)) |=> rdata[ssim_pkg::BIT_COMPARE_ZERO_HIT])
    else $error("compare zero flag missing from status read");

  a_rd_cmp1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && $past(src.compare_one_event)) |=> rdata[ssim_pkg::BIT_COMPARE_ONE_HIT])
    else $error("compare one flag missing from status read");

  a_rd_tx_sync_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && $past(src.tx_sync_event)) |=> rdata[ssim_pkg::BIT_TX_SYNC_EVENT])
    else $error("tx sync flag missing from status read");

  a_rd_rx_sync_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_status && $past(src.rx_sync_event)) |=> rdata[ssim_pkg::BIT_RX_SYNC_EVENT])
    else $error("rx sync flag missing from status read");

  // interrupt output
  a_irq_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((status & irq_mask) == '0) |=> !irq)
    else $error("interrupt high with nothing unmasked");

  a_irq_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((status & irq_mask) != '0) |=> irq)
    else $error("interrupt low with an unmasked flag");
endmodule : ssim_irq_mask

// file: src/ssim_pkg.sv
package ssim_pkg;
  localparam int unsigned SRC_W = 12;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK_VIEW = 8'h0c;
  localparam logic [SRC_W-1:0] MASK_RESET = 12'h000;
  localparam logic [SRC_W-1:0] STATUS_RESET = 12'h000;
  localparam logic [SRC_W-1:0] STICKY_BITS = 12'hf20;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam int unsigned BIT_TX_HOLDING_FREE = 0;
  localparam int unsigned BIT_TX_ALL_DRAINED = 1;
  localparam int unsigned BIT_TX_DMA_COUNT_END = 2;
  localparam int unsigned BIT_TX_DMA_BUFFERS_EMPTY = 3;
  localparam int unsigned BIT_RX_WORD_AVAILABLE = 4;
  localparam int unsigned BIT_RX_OVERRUN_FLAG = 5;
  localparam int unsigned BIT_RX_DMA_COUNT_END = 6;
  localparam int unsigned BIT_RX_DMA_BUFFERS_FULL = 7;
  localparam int unsigned BIT_COMPARE_ZERO_HIT = 8;
  localparam int unsigned BIT_COMPARE_ONE_HIT = 9;
  localparam int unsigned BIT_TX_SYNC_EVENT = 10;
  localparam int unsigned BIT_RX_SYNC_EVENT = 11;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } ssim_bus_req_t;

  typedef struct packed {
    logic tx_holding_free;
    logic tx_all_drained;
    logic tx_dma_count_end;
    logic tx_dma_counter_zero;
    logic tx_dma_next_counter_zero;
    logic rx_word_available;
    logic rx_overrun_event;
    logic rx_dma_count_end;
    logic rx_dma_counter_zero;
    logic rx_dma_next_counter_zero;
    logic compare_zero_event;
    logic compare_one_event;
    logic tx_sync_event;
    logic rx_sync_event;
  } ssim_src_t;
endpackage : ssim_pkg

// file: src/ssim_sticky.sv
`timescale 1ns/1ps
module ssim_sticky
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);
  // set wins over a clearing read
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      flag <= 1'b0;
    else if (set_evt)
      flag <= 1'b1;
    else if (clr_evt)
      flag <= 1'b0;
  end

  a_set_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    set_evt |=> flag)
    else $error("sticky flag lost its event");
endmodule : ssim_sticky
